// ==== include/pxj_pkg.sv ====
package pxj_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned MAJOR_CYCLE_NS = 250;
  localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam logic [3:0] MAJOR_CYCLE_CLKS = 4'(MAJOR_CYCLE_NS / CLK_PERIOD_NS);
  localparam logic [5:0] OP_PASS = 6'o00;
  localparam logic [5:0] OP_LONG_JUMP_IDX = 6'o01;
  localparam logic [5:0] OP_RETURN_JUMP_IDX = 6'o02;
  localparam logic [5:0] OP_LOAD_RELOC = 6'o24;
  localparam logic [5:0] OP_STORE_RELOC = 6'o25;
  localparam logic [5:0] OP_SWAP = 6'o26;
  localparam logic [5:0] OP_CM_READ = 6'o60;
  localparam logic [5:0] OP_CM_BLOCK_READ = 6'o61;
  localparam logic [5:0] OP_CM_WRITE = 6'o62;
  localparam logic [5:0] OP_CM_BLOCK_WRITE = 6'o63;
  localparam logic [5:0] OP_CHAN_TEST_LO = 6'o64;
  localparam logic [5:0] OP_CHAN_TEST_HI = 6'o67;
  localparam logic [5:0] OP_CHAN_BLOCK_IN = 6'o71;
  localparam logic [5:0] OP_CHAN_BLOCK_OUT = 6'o73;
  localparam logic [5:0] SUB_UNCOND = 6'o00;
  localparam logic [5:0] SUB_MONITOR = 6'o10;
  localparam logic [5:0] SUB_MONITOR_MA = 6'o20;
  localparam int unsigned ACC_SELECT_BIT = 17;
  localparam logic [7:0] CYC_ONE = 8'd1;
  localparam logic [7:0] CYC_SWAP = 8'd2;
  localparam logic [7:0] CYC_LONG_JUMP = 8'd3;
  localparam logic [7:0] CYC_RETURN_JUMP = 8'd4;
  localparam logic [7:0] CYC_LOAD_RELOC = 8'd3;
  localparam logic [7:0] CYC_STORE_RELOC = 8'd4;
  localparam logic [7:0] CYC_DIRECT = 8'd2;
  localparam logic [7:0] CYC_INDIRECT = 8'd3;
  localparam logic [7:0] CYC_INDEXED = 8'd4;
  localparam logic [7:0] CYC_REPLACE_ADD_EXTRA = 8'd2;
  localparam logic [7:0] CYC_REPLACE_ONE_EXTRA = 8'd3;
  localparam logic [7:0] CYC_CM_READ = 8'd12;
  localparam logic [7:0] CYC_CM_WRITE = 8'd6;
  localparam logic [7:0] CYC_CM_BLOCK_READ_SETUP = 8'd7;
  localparam logic [7:0] CYC_CM_BLOCK_WRITE_SETUP = 8'd6;
  localparam logic [7:0] CYC_CM_PER_WORD = 8'd5;
  localparam logic [7:0] CYC_CHAN = 8'd2;
  localparam logic [7:0] CYC_CHAN_BLOCK_SETUP = 8'd5;
  localparam logic [7:0] CYC_CHAN_WORD_APART = 8'd1;
  localparam logic [7:0] CYC_CHAN_WORD_SHARED = 8'd2;

  typedef struct packed {
    logic [5:0] opcode;
    logic [5:0] subcode;
    logic [17:0] accumulator;
    logic [17:0] relocation;
    logic [11:0] word_count;
    logic shared_slot;
  } pxj_instr_type;

  typedef struct packed {
    logic [17:0] package_address;
    logic use_outgoing_monitor_address;
    logic set_monitor_mode_flag;
  } pxj_swap_req_type;
endpackage

// ==== core/pxj_timing_core.sv ====
`timescale 1ns/100ps
// Contract
// - subcode 00 always requests a package swap, monitor flag left alone.
// - address is relocation plus accumulator when select bit set, else accumulator.
// - monitor swap passes when processor already in monitor mode.
// - monitor swap in job mode requests swap and sets monitor flag.
// - swap to monitor address passes in monitor mode, else swaps, sets flag.
// - swap to monitor address uses outgoing package monitor address, absolute.
// - after a swap request, stall until the exchange completes.
// - all counts are in 250 ns major cycles.
// - each swap instruction takes two major cycles, no conflicts.
// - indexed long jump three cycles, indexed return jump four.
// - relocation load three cycles, relocation store four.
// - direct ops two, replace add four, replace add or subtract one five.
// - indirect ops three, replace add five, replace one six.
// - indexed ops four, replace add six, replace one seven.
// - single central read twelve cycles, single central write six.
// - central reads may add one resynchronisation trip.
// - block central read seven plus five per word.
// - block central write six plus five per word.
// - channel tests and flag set and clear take two cycles.
// - single channel transfers, activate, deactivate, functions take two.
// - block channel five plus one per word apart, two when shared.
// - address select bit is accumulator bit 17.
module pxj_timing_core (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic instr_valid,
  output logic instr_ready,
  input pxj_pkg::pxj_instr_type instr,
  input wire logic monitor_mode_flag,
  input wire logic resync_trip,
  input wire logic conflict_stall,
  output logic swap_req_valid,
  input wire logic swap_req_ready,
  output pxj_pkg::pxj_swap_req_type swap_req,
  input wire logic swap_done,
  output logic major_cycle_tick,
  output logic instr_done,
  output logic [15:0] cycles_used
);
  import pxj_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_SWAP_REQ, ST_SWAP_WAIT} pxj_state_type;

  pxj_state_type state_reg;
  logic [3:0] div_reg;
  logic [15:0] remain_reg;
  logic [15:0] used_reg;
  logic resync_pending_reg;
  logic swap_needed_reg;
  logic done_reg;
  logic [15:0] base_cycles;
  logic [15:0] word_cost;
  logic is_swap;
  logic swap_active;
  logic set_flag;
  logic use_ma;
  logic [17:0] pkg_addr;
  logic is_cm_read;
  logic take;

  // major cycle enable from the 20 MHz clock
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      div_reg <= 4'h0;
    end else if (div_reg == MAJOR_CYCLE_CLKS - 4'h1) begin
      div_reg <= 4'h0;
    end else begin
      div_reg <= div_reg + 4'h1;
    end
  end
  assign major_cycle_tick = (div_reg == MAJOR_CYCLE_CLKS - 4'h1);

  assign is_swap = (instr.opcode == OP_SWAP);

  always_comb begin
    swap_active = 1'b0;
    set_flag = 1'b0;
    use_ma = 1'b0;
    if (is_swap) begin
      case (instr.subcode)
        SUB_MONITOR: begin
          swap_active = !monitor_mode_flag;
          set_flag = 1'b1;
        end
        SUB_MONITOR_MA: begin
          swap_active = !monitor_mode_flag;
          set_flag = 1'b1;
          use_ma = 1'b1;
        end
        default: begin
          swap_active = 1'b1;
          set_flag = 1'b0;
        end
      endcase
    end
  end

  always_comb begin
    if (use_ma) begin
      pkg_addr = 18'h00000;
    end else if (instr.accumulator[ACC_SELECT_BIT]) begin
      // wraps at 18 bits like the address path it feeds
      pkg_addr = 18'(instr.relocation + instr.accumulator);
    end else begin
      pkg_addr = instr.accumulator;
    end
  end

  always_comb begin
    word_cost = 16'h0000;
    case (instr.opcode)
      OP_CM_BLOCK_READ, OP_CM_BLOCK_WRITE: begin
        word_cost = 16'(instr.word_count) * 16'(CYC_CM_PER_WORD);
      end
      OP_CHAN_BLOCK_IN, OP_CHAN_BLOCK_OUT: begin
        word_cost = 16'(instr.word_count) * (instr.shared_slot ? 16'(CYC_CHAN_WORD_SHARED) :
                    16'(CYC_CHAN_WORD_APART));
      end
      default: begin
        word_cost = 16'h0000;
      end
    endcase
  end

  always_comb begin
    base_cycles = 16'(CYC_ONE);
    if (instr.opcode == OP_LONG_JUMP_IDX) begin
      base_cycles = 16'(CYC_LONG_JUMP);
    end else if (instr.opcode == OP_RETURN_JUMP_IDX) begin
      base_cycles = 16'(CYC_RETURN_JUMP);
    end else if (instr.opcode == OP_LOAD_RELOC) begin
      base_cycles = 16'(CYC_LOAD_RELOC);
    end else if (instr.opcode == OP_STORE_RELOC) begin
      base_cycles = 16'(CYC_STORE_RELOC);
    end else if (is_swap) begin
      base_cycles = 16'(CYC_SWAP);
    end else if (instr.opcode[5:3] == 3'h2 && !instr.opcode[2]) begin
      base_cycles = 16'(CYC_DIRECT); // 20-23 direct d m forms
    end else if (instr.opcode[5:3] >= 3'h3 && instr.opcode[5:3] <= 3'h5) begin
      // 3x direct, 4x indirect, 5x indexed
      case (instr.opcode[5:3])
        3'h3: base_cycles = 16'(CYC_DIRECT);
        3'h4: base_cycles = 16'(CYC_INDIRECT);
        default: base_cycles = 16'(CYC_INDEXED);
      endcase
      if (instr.opcode[2:0] == 3'h5) begin
        base_cycles = base_cycles + 16'(CYC_REPLACE_ADD_EXTRA);
      end else if (instr.opcode[2:1] == 2'h3) begin
        base_cycles = base_cycles + 16'(CYC_REPLACE_ONE_EXTRA);
      end
    end else if (instr.opcode == OP_CM_READ) begin
      base_cycles = 16'(CYC_CM_READ);
    end else if (instr.opcode == OP_CM_WRITE) begin
      base_cycles = 16'(CYC_CM_WRITE);
    end else if (instr.opcode == OP_CM_BLOCK_READ) begin
      base_cycles = 16'(CYC_CM_BLOCK_READ_SETUP) + word_cost;
    end else if (instr.opcode == OP_CM_BLOCK_WRITE) begin
      base_cycles = 16'(CYC_CM_BLOCK_WRITE_SETUP) + word_cost;
    end else if (instr.opcode >= OP_CHAN_TEST_LO && instr.opcode <= OP_CHAN_TEST_HI) begin
      base_cycles = 16'(CYC_CHAN);
    end else if (instr.opcode == OP_CHAN_BLOCK_IN || instr.opcode == OP_CHAN_BLOCK_OUT) begin
      base_cycles = 16'(CYC_CHAN_BLOCK_SETUP) + word_cost;
    end else if (instr.opcode[5:3] == 3'h7) begin
      base_cycles = 16'(CYC_CHAN);
    end
  end

  assign is_cm_read = (instr.opcode == OP_CM_READ) || (instr.opcode == OP_CM_BLOCK_READ);
  assign instr_ready = (state_reg == ST_IDLE) && major_cycle_tick;
  assign take = instr_valid && instr_ready;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      remain_reg <= 16'h0000;
      used_reg <= 16'h0000;
      resync_pending_reg <= 1'b0;
      swap_needed_reg <= 1'b0;
      swap_req <= '0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (take) begin
            remain_reg <= base_cycles;
            used_reg <= 16'h0000;
            resync_pending_reg <= is_cm_read && resync_trip;
            swap_needed_reg <= swap_active;
            swap_req <= '{package_address: pkg_addr, use_outgoing_monitor_address: use_ma,
                          set_monitor_mode_flag: set_flag};
            state_reg <= swap_active ? ST_SWAP_REQ : ST_RUN;
          end
        end
        ST_SWAP_REQ: begin
          if (major_cycle_tick) begin
            used_reg <= used_reg + 16'h0001;
            if (remain_reg > 16'h0001) begin
              remain_reg <= remain_reg - 16'h0001;
            end
          end
          if (swap_req_ready) begin
            state_reg <= ST_SWAP_WAIT;
          end
        end
        ST_SWAP_WAIT: begin
          // stall: counting continues but the instruction cannot end early
          if (major_cycle_tick) begin
            used_reg <= used_reg + 16'h0001;
            if (remain_reg > 16'h0001) begin
              remain_reg <= remain_reg - 16'h0001;
            end
          end
          if (swap_done) begin
            swap_needed_reg <= 1'b0;
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (major_cycle_tick) begin
            used_reg <= used_reg + 16'h0001;
            if (conflict_stall) begin
              remain_reg <= remain_reg;
            end else if (remain_reg > 16'h0001) begin
              remain_reg <= remain_reg - 16'h0001;
            end else if (resync_pending_reg) begin
              resync_pending_reg <= 1'b0;
            end else begin
              state_reg <= ST_IDLE;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      done_reg <= 1'b0;
      cycles_used <= 16'h0000;
    end else begin
      done_reg <= (state_reg == ST_RUN) && major_cycle_tick && !conflict_stall &&
                  (remain_reg <= 16'h0001) && !resync_pending_reg;
      if ((state_reg == ST_RUN) && major_cycle_tick && !conflict_stall &&
          (remain_reg <= 16'h0001) && !resync_pending_reg) begin
        cycles_used <= used_reg + 16'h0001;
      end
    end
  end

  assign instr_done = done_reg;
  assign swap_req_valid = (state_reg == ST_SWAP_REQ) && swap_needed_reg;
endmodule

// ==== test/pxj_timing_core_asserts.sv ====
`timescale 1ns/100ps
module pxj_timing_core_asserts (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic instr_valid,
  input wire logic instr_ready,
  input pxj_pkg::pxj_instr_type instr,
  input wire logic monitor_mode_flag,
  input wire logic swap_req_valid,
  input wire logic swap_req_ready,
  input pxj_pkg::pxj_swap_req_type swap_req,
  input wire logic major_cycle_tick,
  input wire logic instr_done
);
  import pxj_pkg::*;
  wire logic swp = instr_valid && instr_ready && instr.opcode == OP_SWAP;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  AST_TICK_EVERY_FIVE: assert property (major_cycle_tick |=> !major_cycle_tick [*4] ##1 major_cycle_tick)
    else $error("major tick spacing wrong");
  AST_TAKE_ON_TICK: assert property (instr_ready |-> major_cycle_tick)
    else $error("ready off the tick");
  AST_PLAIN_ADDR: assert property (swp && instr.subcode == SUB_UNCOND |=> swap_req_valid
    && !swap_req.set_monitor_mode_flag && swap_req.package_address == ($past(instr.accumulator[17]) ?
    $past(instr.relocation) + $past(instr.accumulator) : $past(instr.accumulator)))
    else $error("plain swap request wrong");
  AST_MON_PASS: assert property (swp && (instr.subcode == SUB_MONITOR || instr.subcode == SUB_MONITOR_MA)
    && monitor_mode_flag |=> !swap_req_valid [*8])
    else $error("pass raised a swap");
  AST_MON_SWAP: assert property (swp && instr.subcode == SUB_MONITOR && !monitor_mode_flag
    |=> swap_req_valid && swap_req.set_monitor_mode_flag && !swap_req.use_outgoing_monitor_address)
    else $error("monitor swap request wrong");
  AST_MA_SWAP: assert property (swp && instr.subcode == SUB_MONITOR_MA && !monitor_mode_flag
    |=> swap_req_valid && swap_req.set_monitor_mode_flag && swap_req.use_outgoing_monitor_address)
    else $error("monitor address swap wrong");
  AST_STALL: assert property (swap_req_valid |-> !instr_ready && !instr_done)
    else $error("ran on during swap");
  AST_REQ_HOLD: assert property (swap_req_valid && !swap_req_ready |=> swap_req_valid && $stable(swap_req))
    else $error("swap request dropped");
  AST_DIRECT_TIME: assert property (instr_valid && instr_ready && instr.opcode == 6'h18 |-> ##[10:11] instr_done)
    else $error("direct add timing wrong");
  AST_DONE_PULSE: assert property (instr_done |=> !instr_done)
    else $error("done longer than a clock");
endmodule

// ==== test/pxj_cp_model.sv ====
`timescale 1ns/100ps
module pxj_cp_model (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic slow,
  input wire logic swap_req_valid,
  input pxj_pkg::pxj_swap_req_type swap_req,
  output logic swap_req_ready,
  output logic swap_done,
  output int n_seen,
  output pxj_pkg::pxj_swap_req_type last_req
);
  import pxj_pkg::*;
  int wait_cnt;
  int acc_cnt;
  // slow mode sits on both the accept and the swap itself
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      swap_req_ready <= 1'b0;
      swap_done <= 1'b0;
      n_seen <= 0;
      last_req <= '0;
      wait_cnt <= 0;
      acc_cnt <= 0;
    end else begin
      swap_req_ready <= 1'b0;
      swap_done <= 1'b0;
      if (wait_cnt != 0) begin
        wait_cnt <= wait_cnt - 1;
        swap_done <= (wait_cnt == 1);
      end else if (swap_req_valid && !swap_req_ready) begin
        if (acc_cnt >= (slow ? 12 : 0)) begin
          swap_req_ready <= 1'b1;
          last_req <= swap_req;
          n_seen <= n_seen + 1;
          wait_cnt <= slow ? 30 : 2;
          acc_cnt <= 0;
        end else begin
          acc_cnt <= acc_cnt + 1;
        end
      end
    end
  end
endmodule

// ==== test/pxj_exchange_jump_and_cycle_timing_bench.sv ====
`timescale 1ns/100ps
module pxj_exchange_jump_and_cycle_timing_bench;
  import pxj_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic instr_valid = 1'b0;
  logic monitor_mode_flag = 1'b0;
  logic resync_trip = 1'b0;
  logic conflict_stall = 1'b0;
  logic slow = 1'b0;
  logic [17:0] acc = 18'h0;
  logic [17:0] rel = 18'h00100;
  pxj_instr_type instr = '0;
  logic instr_ready, swap_req_valid, swap_req_ready, swap_done, major_cycle_tick, instr_done;
  logic [15:0] cycles_used;
  logic [15:0] cyc;
  pxj_swap_req_type swap_req, last_req;
  int n_seen;
  int miscompares = 0;
  int n_tests = 0;
  pxj_timing_core dut_u (.clk_sys, .reset_n, .instr_valid, .instr_ready, .instr, .monitor_mode_flag, .resync_trip,
    .conflict_stall, .swap_req_valid, .swap_req_ready, .swap_req, .swap_done, .major_cycle_tick, .instr_done,
    .cycles_used);
  pxj_cp_model cp_u (.clk_sys, .reset_n, .slow, .swap_req_valid, .swap_req, .swap_req_ready, .swap_done, .n_seen,
    .last_req);
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end
  task finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task check(input logic [19:0] seen, input logic [19:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %0h expected %0h", $time, seen, exp);
    end
  endtask
  // offered at a falling edge; taken at the tick edge after ready shows
  task run(input logic [5:0] op, input logic [5:0] sub, input logic [11:0] wc, input logic sh,
    output logic [15:0] c);
    int i;
    i = 0;
    instr = '{op, sub, acc, rel, wc, sh};
    instr_valid = 1'b1;
    while (instr_ready !== 1'b1 && i < 20) begin
      @(negedge clk_sys);
      i++;
    end
    if (i >= 20) begin
      miscompares++;
      finish_test();
    end
    @(negedge clk_sys);
    instr_valid = 1'b0;
    i = 0;
    while (instr_done !== 1'b1 && i < 400) begin
      @(negedge clk_sys);
      i++;
    end
    if (i >= 400) begin
      miscompares++;
      finish_test();
    end
    c = cycles_used;
    @(negedge clk_sys);
  endtask
  task t_table;
    logic [5:0] ops [21] = '{6'h00, 6'h01, 6'h02, 6'h14, 6'h15, 6'h18, 6'h1c, 6'h1d, 6'h1e, 6'h1f, 6'h20,
      6'h25, 6'h26, 6'h28, 6'h2d, 6'h2f, 6'h30, 6'h32, 6'h34, 6'h38, 6'h3f};
    int exps [21] = '{1, 3, 4, 3, 4, 2, 2, 4, 5, 5, 3, 5, 6, 4, 6, 7, 12, 6, 2, 2, 2};
    for (int k = 0; k < 21; k++) begin
      run(ops[k], 6'h00, 12'h0, 1'b0, cyc);
      check(20'(cyc), 20'(exps[k]));
    end
    $display("table timing test done");
  endtask
  task t_block;
    run(OP_CM_BLOCK_READ, 6'h00, 12'h002, 1'b0, cyc);
    check(20'(cyc), 20'h00011);
    run(OP_CM_BLOCK_WRITE, 6'h00, 12'h003, 1'b0, cyc);
    check(20'(cyc), 20'h00015);
    run(OP_CHAN_BLOCK_IN, 6'h00, 12'h004, 1'b0, cyc);
    check(20'(cyc), 20'h00009);
    run(OP_CHAN_BLOCK_OUT, 6'h00, 12'h004, 1'b1, cyc);
    check(20'(cyc), 20'h0000d);
    resync_trip = 1'b1;
    run(OP_CM_READ, 6'h00, 12'h0, 1'b0, cyc);
    check(20'(cyc), 20'h0000d);
    resync_trip = 1'b0;
    // one stalled tick lands inside the run wherever the take falls
    fork
      begin
        repeat (7) @(negedge clk_sys);
        conflict_stall = 1'b1;
        repeat (5) @(negedge clk_sys);
        conflict_stall = 1'b0;
      end
    join_none
    run(6'h1d, 6'h00, 12'h0, 1'b0, cyc);
    check(20'(cyc), 20'h00005);
    $display("block and stall test done");
  endtask
  task swp(input logic [5:0] sub, input logic m, input logic [17:0] a, input logic nw, input logic [17:0] ea,
    input logic [1:0] ef);
    int n0;
    n0 = n_seen;
    monitor_mode_flag = m;
    acc = a;
    run(OP_SWAP, sub, 12'h0, 1'b0, cyc);
    check(20'(cyc), 20'h00002);
    check(20'(n_seen - n0), 20'(nw));
    if (nw) begin
      check(20'(last_req.package_address), 20'(ea));
      check(20'({last_req.use_outgoing_monitor_address, last_req.set_monitor_mode_flag}), 20'(ef));
    end
  endtask
  task t_swap;
    swp(SUB_UNCOND, 1'b1, 18'h20010, 1'b1, 18'h20110, 2'b00);
    swp(SUB_UNCOND, 1'b0, 18'h1ffff, 1'b1, 18'h1ffff, 2'b00);
    swp(SUB_MONITOR, 1'b1, 18'h20010, 1'b0, 18'h0, 2'b00);
    swp(SUB_MONITOR, 1'b0, 18'h20010, 1'b1, 18'h20110, 2'b01);
    swp(SUB_MONITOR_MA, 1'b1, 18'h20010, 1'b0, 18'h0, 2'b00);
    swp(SUB_MONITOR_MA, 0, 18'h20010, 1'b1, 18'h0, 2'b11);
    slow = 1'b1;
    run(OP_SWAP, SUB_UNCOND, 12'h0, 1'b0, cyc);
    check(20'(cyc > 16'h0002), 20'h00001);
    slow = 1'b0;
    $display("swap test done");
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys);
    reset_n = 1'b1;
    t_table();
    t_block();
    t_swap();
    finish_test();
  end
endmodule
bind pxj_timing_core pxj_timing_core_asserts chk_u (.clk_sys, .reset_n, .instr_valid, .instr_ready, .instr,
  .monitor_mode_flag, .swap_req_valid, .swap_req_ready, .swap_req, .major_cycle_tick, .instr_done);
